// ===== hdl/clock_stop_pkg.sv
// Constants and types for the processor clock-stop controller
package clock_stop_pkg;
  localparam int addr_width = 24;
  localparam int fc_width = 3;
  localparam int ipl_width = 3;
  localparam logic [2:0] fc_super_data = 3'h5;
  localparam logic [23:0] trigger_addr_default = 24'hff_fff0;
  localparam logic [2:0] wake_level_default = 3'h7;
  // Bus cycles from match write to operand end (wide: write, opcode, operand; narrow: one more)
  localparam logic [2:0] cycles_wide = 3'h3;
  localparam logic [2:0] cycles_narrow = 3'h4;
  localparam int stable_time_us = 1;
  localparam int clk_period_ns = 20;
  localparam int stable_cycles = (stable_time_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  typedef enum logic [3:0] {
    st_run = 4'b0001,
    st_count = 4'b0010,
    st_stopped = 4'b0100,
    st_resume = 4'b1000
  } mode_t;
endpackage

// ===== hdl/processor_clock_stop_ctrl.sv
// Clock-stop and wake controller that drives a static processor clock input
`timescale 1ns/1ps
module processor_clock_stop_ctrl #(
  parameter logic [23:0] trigger_addr = clock_stop_pkg::trigger_addr_default,
  parameter logic [2:0] wake_level = clock_stop_pkg::wake_level_default,
  parameter logic [7:0] stable_count = 8'(clock_stop_pkg::stable_cycles)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [clock_stop_pkg::addr_width-1:0] address_lines,
  input wire logic [clock_stop_pkg::fc_width-1:0] function_code_lines,
  input wire logic read_not_write,
  input wire logic addr_strobe_n,
  input wire logic narrow_bus,
  input wire logic [clock_stop_pkg::ipl_width-1:0] interrupt_priority_lines_n,
  input wire logic sys_clk_stable,
  output logic proc_clk,
  output logic lp_addr_hit,
  output logic clock_resume_req,
  output logic bus_request,
  output logic sleeping
);
  import clock_stop_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    logic [1:0] as_sync;
    logic [1:0] rnw_sync;
    logic [1:0] narrow_sync;
    logic [5:0] ipl_sync;
    logic [47:0] addr_sync;
    logic [5:0] fc_sync;
    logic as_prev;
    mode_t mode;
    logic [2:0] cycles;
    logic [7:0] stable_cnt;
    logic hit;
    logic resume;
    logic breq;
  } state_t;

  state_t s, next_s;
  logic gate_en;
  logic as_start;
  logic match;
  logic wake;
  logic [2:0] need;

  function automatic logic [2:0] active_level(input logic [2:0] lines_n);
    active_level = ~lines_n;
  endfunction

  // ============================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.as_sync = {s.as_sync[0], ~addr_strobe_n};
    next_s.rnw_sync = {s.rnw_sync[0], read_not_write};
    next_s.narrow_sync = {s.narrow_sync[0], narrow_bus};
    next_s.ipl_sync = {s.ipl_sync[2:0], interrupt_priority_lines_n};
    next_s.addr_sync = {s.addr_sync[23:0], address_lines};
    next_s.fc_sync = {s.fc_sync[2:0], function_code_lines};
    next_s.as_prev = s.as_sync[1];
    as_start = s.as_sync[1] && !s.as_prev;
    match = as_start && (s.addr_sync[47:24] == trigger_addr) && !s.rnw_sync[1]
      && (s.fc_sync[5:3] == fc_super_data);
    need = s.narrow_sync[1] ? cycles_narrow : cycles_wide;
    wake = active_level(s.ipl_sync[5:3]) >= wake_level;
    next_s.hit = match;
    case (s.mode)
      st_run: begin
        next_s.cycles = 3'h0;
        next_s.resume = 1'b0;
        if (match) begin
          next_s.mode = st_count;
          next_s.cycles = 3'h1;
        end
      end
      st_count: begin
        if (as_start) begin
          next_s.cycles = s.cycles + 3'h1;
        end
        // Arbitrate during operand fetch to float outputs
        if (s.cycles == need) begin
          next_s.breq = 1'b1;
        end
        if (s.cycles == need && !s.as_sync[1]) begin
          next_s.mode = st_stopped;
        end
      end
      st_stopped: begin
        next_s.stable_cnt = 8'h00;
        if (wake) begin
          next_s.mode = st_resume;
        end
      end
      st_resume: begin
        if (!sys_clk_stable) begin
          next_s.stable_cnt = 8'h00;
        end else if (s.stable_cnt != stable_count) begin
          next_s.stable_cnt = s.stable_cnt + 8'h01;
        end else begin
          next_s.resume = 1'b1;
          next_s.breq = 1'b0;
          next_s.mode = st_run;
        end
      end
      default: begin
        next_s.mode = st_run;
      end
    endcase
  end

  // ============================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.mode <= st_run;
      s.as_sync <= 2'h0;
      s.ipl_sync <= 6'h3f;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Glitch-free clock gate, enable latched on the falling edge
  always_ff @(negedge core_clk) begin
    if (rst) begin
      gate_en <= 1'b1;
    end else begin
      gate_en <= (s.mode != st_stopped) && (s.mode != st_resume);
    end
  end

  assign proc_clk = core_clk & gate_en;
  assign lp_addr_hit = s.hit;
  assign clock_resume_req = s.resume;
  assign bus_request = s.breq;
  assign sleeping = !gate_en;

  // ============================================================
  // Check helpers
  logic gate_at_rise;

  always_ff @(posedge core_clk) begin
    gate_at_rise <= gate_en;
  end

  // ============================================================
  // Checks
  sequence seq_counting;
    s.mode == st_count;
  endsequence

  sequence seq_stop_entry;
    s.mode == st_count ##1 s.mode == st_stopped;
  endsequence

  sequence seq_resume_entry;
    s.mode == st_stopped ##1 s.mode == st_resume;
  endsequence

  chk_reset_state: assert property (@(posedge core_clk)
    $fell(rst) |-> s.mode == st_run && s.cycles == 3'h0 && !bus_request && gate_en)
    else $error("state not cleared by reset");
  chk_hit_write_only: assert property (@(posedge core_clk) disable iff (rst)
    lp_addr_hit |-> $past(s.rnw_sync[1]) == 1'b0)
    else $error("hit on read cycle");
  chk_hit_needs_super: assert property (@(posedge core_clk) disable iff (rst)
    lp_addr_hit |-> $past(s.fc_sync[5:3]) == fc_super_data)
    else $error("hit without supervisor data code");
  chk_hit_addr_match: assert property (@(posedge core_clk) disable iff (rst)
    lp_addr_hit |-> $past(s.addr_sync[47:24]) == trigger_addr)
    else $error("hit on wrong address");
  chk_hit_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    lp_addr_hit |=> !lp_addr_hit)
    else $error("hit longer than one cycle");
  chk_count_from_hit: assert property (@(posedge core_clk) disable iff (rst)
    lp_addr_hit && $past(s.mode) == st_run |-> seq_counting)
    else $error("count did not start");
  chk_no_early_stop: assert property (@(posedge core_clk) disable iff (rst)
    s.mode == st_count && s.cycles != need |=> s.mode != st_stopped)
    else $error("stopped before operand fetch");
  chk_stop_count_need: assert property (@(posedge core_clk) disable iff (rst)
    seq_stop_entry |-> $past(s.cycles) == $past(need))
    else $error("stopped on wrong cycle count");
  chk_stop_after_count: assert property (@(posedge core_clk) disable iff (rst)
    $fell(gate_en) |-> $past(s.mode, 2) == st_count)
    else $error("stopped without counting");
  chk_breq_in_fetch: assert property (@(posedge core_clk) disable iff (rst)
    $rose(bus_request) |-> $past(s.mode) == st_count && $past(s.cycles) == $past(need))
    else $error("bus request outside operand fetch");
  chk_gate_low_only: assert property (@(negedge core_clk) disable iff (rst)
    gate_en == gate_at_rise)
    else $error("gate changed while clock high");
  chk_stopped_gated: assert property (@(posedge core_clk) disable iff (rst)
    (s.mode == st_stopped || s.mode == st_resume) |-> sleeping)
    else $error("clock running while stopped");
  chk_run_clocked: assert property (@(posedge core_clk) disable iff (rst)
    (s.mode == st_run || s.mode == st_count) |-> !sleeping)
    else $error("clock stopped while running");
  chk_wake_level: assert property (@(posedge core_clk) disable iff (rst)
    seq_resume_entry |-> $past(wake))
    else $error("woke without interrupt level");
  chk_no_resume_unstable: assert property (@(posedge core_clk) disable iff (rst)
    s.mode == st_resume && !sys_clk_stable |=> !clock_resume_req)
    else $error("resume raised on unstable clock");
  chk_stable_wait: assert property (@(posedge core_clk) disable iff (rst)
    $rose(clock_resume_req) |-> $past(s.stable_cnt) == stable_count)
    else $error("resume before stable wait ended");
  chk_resume_stable: assert property (@(posedge core_clk) disable iff (rst)
    $rose(clock_resume_req) |-> $past(sys_clk_stable))
    else $error("resume while clock unstable");
  chk_resume_gate_on: assert property (@(posedge core_clk) disable iff (rst)
    $rose(clock_resume_req) |-> ##1 gate_en)
    else $error("clock not restarted");
  chk_resume_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
    clock_resume_req |=> !clock_resume_req)
    else $error("resume longer than one cycle");
  chk_breq_released: assert property (@(posedge core_clk) disable iff (rst)
    clock_resume_req |-> !bus_request)
    else $error("bus request held at resume");
endmodule // processor_clock_stop_ctrl

// ===== verification/proc_bus_model.sv
// Behavioural processor bus and interrupt model for the clock-stop controller
`timescale 1ns/1ps
module proc_bus_model (
  input wire logic core_clk,
  output logic [23:0] address_lines,
  output logic [2:0] function_code_lines,
  output logic read_not_write,
  output logic addr_strobe_n,
  output logic [2:0] interrupt_priority_lines_n
);
  // ==========================================
  // Idle bus
  initial begin
    address_lines = 24'h00_0000;
    function_code_lines = 3'h0;
    read_not_write = 1'b1;
    addr_strobe_n = 1'b1;
    interrupt_priority_lines_n = 3'h7;
  end
  // ==========================================
  // One bus cycle; address released as inverse afterwards
  // Grant not watched, one-wire arbitration (bus request only, no grant input)
  task automatic cycle(input logic [23:0] a, input logic [2:0] fc, input logic rnw);
    address_lines <= a;
    function_code_lines <= fc;
    read_not_write <= rnw;
    repeat (2) @(posedge core_clk);
    addr_strobe_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    addr_strobe_n <= 1'b1;
    address_lines <= ~a;
    function_code_lines <= ~fc;
    read_not_write <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // Active low interrupt level
  task automatic level(input logic [2:0] l);
    interrupt_priority_lines_n <= ~l;
  endtask
endmodule // proc_bus_model

// ===== verification/processor_clock_stop_ctrl_test.sv
// Self-checking bench for the processor clock-stop controller
`timescale 1ns/1ps
module processor_clock_stop_ctrl_test;
  import clock_stop_pkg::*;
  localparam logic [23:0] trig = 24'h12_3456;
  logic core_clk = 0, rst = 1, narrow_bus = 0, sys_clk_stable = 0;
  logic [23:0] address_lines;
  logic [2:0] function_code_lines, interrupt_priority_lines_n;
  logic read_not_write, addr_strobe_n, proc_clk, lp_addr_hit, clock_resume_req;
  logic bus_request, sleeping;
  int n_errors = 0, total_checks = 0, n_hit = 0;
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) if (lp_addr_hit === 1'b1) n_hit++;
  proc_bus_model i_bus (.core_clk(core_clk), .address_lines(address_lines),
    .function_code_lines(function_code_lines), .read_not_write(read_not_write),
    .addr_strobe_n(addr_strobe_n), .interrupt_priority_lines_n(interrupt_priority_lines_n));
  processor_clock_stop_ctrl #(.trigger_addr(trig), .stable_count(8'h04)) i_dut (
    .core_clk(core_clk), .rst(rst), .address_lines(address_lines),
    .function_code_lines(function_code_lines), .read_not_write(read_not_write),
    .addr_strobe_n(addr_strobe_n), .narrow_bus(narrow_bus),
    .interrupt_priority_lines_n(interrupt_priority_lines_n), .sys_clk_stable(sys_clk_stable),
    .proc_clk(proc_clk), .lp_addr_hit(lp_addr_hit), .clock_resume_req(clock_resume_req),
    .bus_request(bus_request), .sleeping(sleeping));
  // ==========================================
  // Helpers
  task automatic summarize();
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_for(input bit pick_resume, input int lim);
    for (int i = 0; i < lim && (pick_resume ? clock_resume_req : sleeping) !== 1'b1; i++)
      @(negedge core_clk);
    if ((pick_resume ? clock_resume_req : sleeping) !== 1'b1) begin
      n_errors++;
      summarize();
    end
    @(posedge core_clk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    int k;
    k = $urandom(32'hfeb4_8765);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (k = 0; k < 12; k++) i_bus.cycle(k[0] ? 24'($urandom) : trig, k[0] ? 3'h5 : 3'(k % 5), k[1]);
    i_bus.cycle(trig, 3'h5, 1'b1);
    check("stray_hit", 8'(n_hit), 8'h00);
    for (k = 0; k < 2; k++) begin
      narrow_bus <= k[0];
      @(posedge core_clk);
      i_bus.cycle(trig, 3'h5, 1'b0);
      i_bus.cycle(24'h00_0400, 3'h6, 1'b1);
      if (k == 1) i_bus.cycle(24'h00_0402, 3'h6, 1'b1);
      @(negedge core_clk);
      check("hit", 8'(n_hit), 8'(k + 1));
      check("early_stop", {7'h00, sleeping}, 8'h00);
      check("arb_early", {7'h00, bus_request}, 8'h00);
      @(posedge core_clk);
      i_bus.cycle(24'h00_0404, 3'h6, 1'b1);
      wait_for(1'b0, 20);
      check("arb_req", {7'h00, bus_request}, 8'h01);
      i_bus.level(3'h6);
      repeat (12) @(posedge core_clk);
      #1;
      check("gated", {7'h00, proc_clk}, 8'h00);
      check("low_irq", {7'h00, sleeping}, 8'h01);
      @(posedge core_clk);
      i_bus.level(3'h7);
      repeat (20) @(posedge core_clk);
      check("unstable", {7'h00, sleeping}, 8'h01);
      sys_clk_stable <= 1'b1;
      wait_for(1'b1, 30);
      repeat (3) @(posedge core_clk);
      #1;
      check("awake", {6'h00, sleeping, bus_request}, 8'h00);
      check("running", {7'h00, proc_clk}, 8'h01);
      @(posedge core_clk);
      i_bus.level(3'h0);
      sys_clk_stable <= 1'b0;
      repeat (8) @(posedge core_clk);
    end
    summarize();
  end
endmodule // processor_clock_stop_ctrl_test
